// ---- verilog/cdr_regs.sv ----
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_regs (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic IRQ_REQ_I,
  input wire logic [1:0] IRQ_REQ_LEVEL_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_TAKE_O,
  output logic IRQ_EN_O,
  output logic [1:0] IRQ_LEVEL_MASK_O,
  output logic [4:0] BANK_SELECT_O,
  output logic [2:0] DIRECT_WINDOW_SELECT_O
);

  logic rst_meta_r;
  logic rst_n_r;

  // release of reset is synchronised, assertion stays asynchronous
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  cdr_pkg::cdr_state_t state_r;
  cdr_pkg::cdr_state_t state_nxt;
  logic [15:0] ip_r;
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;
  logic [15:0] tacc_r;
  logic [15:0] ix_r;
  logic [15:0] ep_r;
  logic [15:0] sp_r;
  logic [15:0] ps_r;
  logic [15:0] ps_nxt;
  logic [3:0] alu_r;
  logic [10:0] xlate_r;
  logic [31:0] rdata_nxt;
  logic err_nxt;

  // bus decode
  wire access = PSEL_I & PENABLE_I;
  wire take = access & (state_r == cdr_pkg::CDR_ST_REPLY);
  // read data only on the first access edge, so it stands with ready alone
  wire rd_first = access & ~PWRITE_I & (state_r == cdr_pkg::CDR_ST_IDLE);
  wire wr = take & PWRITE_I & ~err_nxt;
  wire hit_ip = (PADDR_I == `CDR_OFF_IP);
  wire hit_acc = (PADDR_I == `CDR_OFF_ACC);
  wire hit_tacc = (PADDR_I == `CDR_OFF_TACC);
  wire hit_ix = (PADDR_I == `CDR_OFF_IX);
  wire hit_ep = (PADDR_I == `CDR_OFF_EP);
  wire hit_sp = (PADDR_I == `CDR_OFF_SP);
  wire hit_ps = (PADDR_I == `CDR_OFF_PS);
  wire hit_alu = (PADDR_I == `CDR_OFF_ALU);
  wire hit_xl = (PADDR_I == `CDR_OFF_XLATE);
  wire hit_stat = (PADDR_I == `CDR_OFF_STAT);
  wire hit_any = hit_ip | hit_acc | hit_tacc | hit_ix | hit_ep | hit_sp | hit_ps | hit_alu
                 | hit_xl | hit_stat;
  wire [15:0] wlo = PWDATA_I[15:0];
  wire [1:0] strb_lo = PSTRB_I[1:0];

  // byte lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nv,
                                          input logic [1:0] st);
    merge16 = {st[1] ? nv[15:8] : old[15:8], st[0] ? nv[7:0] : old[7:0]};
  endfunction

  // state word fields
  wire [4:0] bank_sel = ps_r[`CDR_PS_BANK_HI:`CDR_PS_BANK_LO];
  wire [2:0] win_sel = ps_r[`CDR_PS_WIN_HI:`CDR_PS_WIN_LO];
  wire irq_en = ps_r[`CDR_PS_I];
  wire [1:0] il_mask = ps_r[`CDR_PS_IL_HI:`CDR_PS_IL_LO];

  // address translation
  wire [2:0] gp_idx = xlate_r[2:0];
  wire [7:0] dir_lo = xlate_r[10:3];
  // bank select lands on bits 7:3, index on 2:0, base bit 8
  wire [15:0] gp_addr = {7'h00, `CDR_GP_BASE_BIT, bank_sel, gp_idx};
  wire [3:0] win_base = {1'b0, win_sel} + 4'h1;
  // lower half never remapped; select 0 maps the upper half onto itself
  wire [15:0] dir_addr = dir_lo[7] ? {5'h00, win_base, dir_lo[6:0]} : {8'h00, dir_lo};

  // interrupt admission: lower number wins, mask 0 blocks all
  wire irq_take_nxt = IRQ_REQ_I & irq_en & (IRQ_REQ_LEVEL_I < il_mask);

  // alu operands and datapath
  wire [2:0] op_f = PWDATA_I[`CDR_ALU_OP_HI:`CDR_ALU_OP_LO];
  wire word_f = PWDATA_I[`CDR_ALU_WORD];
  wire alu_go = wr & hit_alu;
  wire cin = ps_r[`CDR_PS_C];
  wire use_c = (op_f == cdr_pkg::CDR_OP_ADDC) | (op_f == cdr_pkg::CDR_OP_SUBC);
  wire ci = use_c & cin;
  wire is_sub = (op_f == cdr_pkg::CDR_OP_SUB) | (op_f == cdr_pkg::CDR_OP_SUBC);
  // byte operations see only the low bytes
  wire [15:0] opa = word_f ? acc_r : {8'h00, acc_r[7:0]};
  wire [15:0] opb = word_f ? tacc_r : {8'h00, tacc_r[7:0]};
  wire [16:0] sum = is_sub ? ({1'b0, opa} - {1'b0, opb} - {16'h0000, ci})
                           : ({1'b0, opa} + {1'b0, opb} + {16'h0000, ci});
  wire [4:0] nib = is_sub ? ({1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, ci})
                          : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci});
  wire [15:0] shl = {opa[14:0], 1'b0};
  wire [15:0] shr = {1'b0, opa[15:1]};
  wire is_shl = (op_f == cdr_pkg::CDR_OP_SHL);
  wire is_shr = (op_f == cdr_pkg::CDR_OP_SHR);
  wire is_arith = (op_f <= cdr_pkg::CDR_OP_SUBC);
  wire [15:0] res = is_arith ? sum[15:0] : (is_shl ? shl : shr);
  wire res_msb = word_f ? res[15] : res[7];
  wire a_msb = word_f ? opa[15] : opa[7];
  wire b_msb = word_f ? opb[15] : opb[7];
  wire res_zero = word_f ? (res == 16'h0000) : (res[7:0] == 8'h00);
  // byte carry is bit 8 of the sum, which for subtraction is the borrow
  wire arith_c = word_f ? sum[16] : sum[8];
  wire shl_c = word_f ? opa[15] : opa[7];
  wire shift_c = is_shl ? shl_c : opa[0];
  wire ovf_add = (a_msb == b_msb) & (res_msb != a_msb);
  wire ovf_sub = (a_msb != b_msb) & (res_msb != a_msb);
  wire arith_v = is_sub ? ovf_sub : ovf_add;
  wire op_ok = is_arith | is_shl | is_shr;

  // bus state machine: one wait state on every access
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cdr_pkg::CDR_ST_IDLE: begin
        if (access) begin
          state_nxt = cdr_pkg::CDR_ST_REPLY;
        end
      end
      cdr_pkg::CDR_ST_REPLY: begin
        state_nxt = cdr_pkg::CDR_ST_IDLE;
      end
      default: begin
        state_nxt = cdr_pkg::CDR_ST_IDLE;
      end
    endcase
  end

  // read mux; data is captured as ready rises
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = ~hit_any;
    if (hit_ip) begin
      rdata_nxt = {16'h0000, ip_r};
    end else if (hit_acc) begin
      rdata_nxt = {16'h0000, acc_r};
    end else if (hit_tacc) begin
      rdata_nxt = {16'h0000, tacc_r};
    end else if (hit_ix) begin
      rdata_nxt = {16'h0000, ix_r};
    end else if (hit_ep) begin
      rdata_nxt = {16'h0000, ep_r};
    end else if (hit_sp) begin
      rdata_nxt = {16'h0000, sp_r};
    end else if (hit_ps) begin
      rdata_nxt = {16'h0000, ps_r};
    end else if (hit_alu) begin
      rdata_nxt = {28'h0000000, alu_r};
    end else if (hit_xl) begin
      rdata_nxt = {dir_addr, gp_addr};
    end else if (hit_stat) begin
      rdata_nxt = {29'h0000000, IRQ_TAKE_O, il_mask == 2'h3, irq_en};
    end
  end

  // accumulator: bus write or alu result, byte ops keep the high byte
  always_comb begin
    acc_nxt = acc_r;
    if (wr & hit_acc) begin
      acc_nxt = merge16(acc_r, wlo, strb_lo);
    end else if (alu_go & op_ok & PSTRB_I[0]) begin
      acc_nxt = word_f ? res : {acc_r[15:8], res[7:0]};
    end
  end

  // state word: bus write or flag update from the alu
  always_comb begin
    ps_nxt = ps_r;
    if (wr & hit_ps) begin
      ps_nxt = merge16(ps_r, wlo, strb_lo);
    end else if (alu_go & op_ok & PSTRB_I[0]) begin
      ps_nxt[`CDR_PS_N] = res_msb;
      ps_nxt[`CDR_PS_Z] = res_zero;
      if (is_arith) begin
        ps_nxt[`CDR_PS_H] = nib[4];
        ps_nxt[`CDR_PS_V] = arith_v;
        ps_nxt[`CDR_PS_C] = arith_c;
      end else begin
        // shifts leave half carry alone; no sign overflow is reported
        ps_nxt[`CDR_PS_V] = 1'b0;
        ps_nxt[`CDR_PS_C] = shift_c;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= cdr_pkg::CDR_ST_IDLE;
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      state_r <= state_nxt;
      PREADY_O <= (state_nxt == cdr_pkg::CDR_ST_REPLY);
      PRDATA_O <= rd_first ? rdata_nxt : 32'h0000_0000;
      PSLVERR_O <= access & (state_r == cdr_pkg::CDR_ST_IDLE) & err_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ip_r <= `CDR_RST_WORD;
      tacc_r <= `CDR_RST_WORD;
      ix_r <= `CDR_RST_WORD;
      ep_r <= `CDR_RST_WORD;
      sp_r <= `CDR_RST_WORD;
    end else begin
      if (wr & hit_ip) begin
        ip_r <= merge16(ip_r, wlo, strb_lo);
      end
      if (wr & hit_tacc) begin
        tacc_r <= merge16(tacc_r, wlo, strb_lo);
      end
      if (wr & hit_ix) begin
        ix_r <= merge16(ix_r, wlo, strb_lo);
      end
      if (wr & hit_ep) begin
        ep_r <= merge16(ep_r, wlo, strb_lo);
      end
      if (wr & hit_sp) begin
        sp_r <= merge16(sp_r, wlo, strb_lo);
      end
    end
  end

  // state word reset clears enable and window select
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_r <= `CDR_RST_WORD;
      ps_r <= `CDR_RST_PS;
    end else begin
      acc_r <= acc_nxt;
      ps_r <= ps_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      alu_r <= `CDR_RST_ALU;
      xlate_r <= `CDR_RST_XLATE;
    end else begin
      if (alu_go & PSTRB_I[0]) begin
        alu_r <= PWDATA_I[3:0];
      end
      if (wr & hit_xl) begin
        if (PSTRB_I[0]) begin
          xlate_r[2:0] <= PWDATA_I[`CDR_XL_IDX_HI:`CDR_XL_IDX_LO];
        end
        if (PSTRB_I[1]) begin
          xlate_r[10:3] <= PWDATA_I[`CDR_XL_DIR_HI:`CDR_XL_DIR_LO];
        end
      end
    end
  end

  // pins other than take mirror the state word one cycle late
  always_ff @(posedge CLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      IRQ_TAKE_O <= 1'b0;
      IRQ_EN_O <= 1'b0;
      IRQ_LEVEL_MASK_O <= 2'h0;
      BANK_SELECT_O <= 5'h00;
      DIRECT_WINDOW_SELECT_O <= 3'h0;
    end else begin
      IRQ_TAKE_O <= irq_take_nxt;
      IRQ_EN_O <= irq_en;
      IRQ_LEVEL_MASK_O <= il_mask;
      BANK_SELECT_O <= bank_sel;
      DIRECT_WINDOW_SELECT_O <= win_sel;
    end
  end

endmodule

// ---- verilog/cdr_consts.svh ----
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH

// register byte offsets on the bus
`define CDR_OFF_IP 8'h00
`define CDR_OFF_ACC 8'h04
`define CDR_OFF_TACC 8'h08
`define CDR_OFF_IX 8'h0c
`define CDR_OFF_EP 8'h10
`define CDR_OFF_SP 8'h14
`define CDR_OFF_PS 8'h18
`define CDR_OFF_ALU 8'h1c
`define CDR_OFF_XLATE 8'h20
`define CDR_OFF_STAT 8'h24

// state word field positions
`define CDR_PS_BANK_HI 15
`define CDR_PS_BANK_LO 11
`define CDR_PS_WIN_HI 10
`define CDR_PS_WIN_LO 8
`define CDR_PS_H 7
`define CDR_PS_I 6
`define CDR_PS_IL_HI 5
`define CDR_PS_IL_LO 4
`define CDR_PS_N 3
`define CDR_PS_Z 2
`define CDR_PS_V 1
`define CDR_PS_C 0

// alu command field positions
`define CDR_ALU_OP_HI 2
`define CDR_ALU_OP_LO 0
`define CDR_ALU_WORD 3

// translate register field positions
`define CDR_XL_IDX_HI 2
`define CDR_XL_IDX_LO 0
`define CDR_XL_DIR_HI 15
`define CDR_XL_DIR_LO 8

// reset values
`define CDR_RST_WORD 16'h0000
`define CDR_RST_PS 16'h0000
`define CDR_RST_ALU 4'h0
`define CDR_RST_XLATE 11'h000

// gp register area base
`define CDR_GP_BASE_BIT 1'b1

`endif

// ---- verilog/cdr_pkg.sv ----
package cdr_pkg;

  typedef enum logic [1:0] {
    CDR_ST_IDLE = 2'b01,
    CDR_ST_REPLY = 2'b10
  } cdr_state_t;

  typedef enum logic [2:0] {
    CDR_OP_ADD = 3'h0,
    CDR_OP_ADDC = 3'h1,
    CDR_OP_SUB = 3'h2,
    CDR_OP_SUBC = 3'h3,
    CDR_OP_SHL = 3'h4,
    CDR_OP_SHR = 3'h5
  } cdr_op_t;

endpackage

// ---- dv/cdr_regs_props.sv ----
`timescale 1ns/1ps
`include "cdr_consts.svh"
module cdr_regs_props (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic IRQ_REQ_I,
  input wire logic [1:0] IRQ_REQ_LEVEL_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic IRQ_TAKE_O,
  input wire logic IRQ_EN_O,
  input wire logic [1:0] IRQ_LEVEL_MASK_O,
  input wire logic [4:0] BANK_SELECT_O,
  input wire logic [2:0] DIRECT_WINDOW_SELECT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // state word write as it lands
  wire logic ps_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && (PADDR_I == `CDR_OFF_PS);
  sequence s_wait;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  a_ready_wait: assert property (s_wait |=> PREADY_O) else $error("ready late");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
  a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("stray rdata");
  a_err_unmapped: assert property (PREADY_O && PADDR_I > `CDR_OFF_STAT |-> PSLVERR_O
    && PRDATA_O == 32'h0) else $error("unmapped not refused");
  a_irq_take: assert property (IRQ_TAKE_O == ($past(IRQ_REQ_I) && IRQ_EN_O &&
    ($past(IRQ_REQ_LEVEL_I) < IRQ_LEVEL_MASK_O))) else $error("take wrong");
  a_mask_block: assert property (IRQ_LEVEL_MASK_O == 2'h0 |-> !IRQ_TAKE_O)
    else $error("mask zero admitted");
  a_sel_hold: assert property (!ps_wr |-> ##2 $stable({BANK_SELECT_O,
    DIRECT_WINDOW_SELECT_O, IRQ_EN_O, IRQ_LEVEL_MASK_O})) else $error("selects moved");
  a_ps_load: assert property (ps_wr && PSTRB_I[1:0] == 2'h3 |-> ##2
    {BANK_SELECT_O, DIRECT_WINDOW_SELECT_O, IRQ_EN_O, IRQ_LEVEL_MASK_O} ==
    {$past(PWDATA_I[15:8], 2), $past(PWDATA_I[6:4], 2)}) else $error("state word not loaded");
endmodule
bind cdr_regs cdr_regs_props i_cdr_regs_props (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .IRQ_REQ_I(IRQ_REQ_I),
  .IRQ_REQ_LEVEL_I(IRQ_REQ_LEVEL_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .IRQ_TAKE_O(IRQ_TAKE_O), .IRQ_EN_O(IRQ_EN_O),
  .IRQ_LEVEL_MASK_O(IRQ_LEVEL_MASK_O), .BANK_SELECT_O(BANK_SELECT_O),
  .DIRECT_WINDOW_SELECT_O(DIRECT_WINDOW_SELECT_O));

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "cdr_consts.svh"
module tb;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0] cmd;
    logic [7:0] ps;
    logic [15:0] r;
    logic [7:0] f;
  } cdr_row_t;
  // byte ops keep the accumulator high byte
  cdr_row_t rows [11] = '{'{16'h0008, 16'h0008, 4'h0, 8'h00, 16'h0010, 8'h80},
    '{16'h127f, 16'h0001, 4'h0, 8'h00, 16'h1280, 8'h8a},
    '{16'h00ff, 16'h0001, 4'h0, 8'h00, 16'h0000, 8'h85},
    '{16'h0010, 16'h0020, 4'h1, 8'h71, 16'h0031, 8'h70},
    '{16'h0010, 16'h0001, 4'h2, 8'h00, 16'h000f, 8'h80},
    '{16'h0005, 16'h0005, 4'h3, 8'h01, 16'h00ff, 8'h89},
    '{16'h0081, 16'h0000, 4'h4, 8'h80, 16'h0002, 8'h81},
    '{16'h0001, 16'h0000, 4'h5, 8'h00, 16'h0000, 8'h05},
    '{16'h7fff, 16'h0001, 4'h8, 8'h00, 16'h8000, 8'h8a},
    '{16'h0000, 16'h0001, 4'ha, 8'h00, 16'hffff, 8'h89},
    '{16'h1234, 16'h0001, 4'h6, 8'h00, 16'h1234, 8'h00}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] lvl = 2'h0;
  logic [31:0] rd;
  logic er;
  logic [31:0] prdata;
  logic pready, perr, take, en;
  logic [1:0] mask;
  logic [4:0] bank;
  logic [2:0] win;
  int error_cnt = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  cdr_regs i_cdr_regs (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .IRQ_REQ_I(req),
    .IRQ_REQ_LEVEL_I(lvl), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .IRQ_TAKE_O(take), .IRQ_EN_O(en), .IRQ_LEVEL_MASK_O(mask), .BANK_SELECT_O(bank),
    .DIRECT_WINDOW_SELECT_O(win));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  task automatic xl(input logic [15:0] ps, input logic [15:0] d, input logic [31:0] exp);
    apb(1'b1, `CDR_OFF_PS, {16'h0, ps});
    apb(1'b1, `CDR_OFF_XLATE, {16'h0, d});
    rdc(`CDR_OFF_XLATE, exp, "xlate");
    chk({24'h0, bank, win}, {24'h0, ps[15:8]}, "sel");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  logic [15:0] ipv [3] = '{16'h0070, 16'h0030, 16'h0040};
  logic [31:0] stv [3] = '{32'h7, 32'h2, 32'h1};
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({21'h0, bank, win, en, mask}, 32'h0, "outs");
    for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0, "rst");
    $display("reset done");
    // all written before any read, so aliasing shows
    for (int i = 0; i < 6; i++) apb(1'b1, 8'(i * 4), 32'hdead_0000 | (i * 16'h1357 + 16'h0a0b));
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'(16'(i * 16'h1357 + 16'h0a0b)), "reg");
    $display("regs done");
    foreach (rows[k]) begin
      apb(1'b1, `CDR_OFF_ACC, {16'h0, rows[k].a});
      apb(1'b1, `CDR_OFF_TACC, {16'h0, rows[k].b});
      apb(1'b1, `CDR_OFF_PS, {24'h0, rows[k].ps});
      apb(1'b1, `CDR_OFF_ALU, {28'h0, rows[k].cmd});
      rdc(`CDR_OFF_ACC, {16'h0, rows[k].r}, "acc");
      rdc(`CDR_OFF_PS, {24'h0, rows[k].f}, "flags");
    end
    $display("alu done");
    xl(16'h2b00, 16'h9006, 32'h0210_012e);
    xl(16'hff00, 16'hff07, 32'h047f_01ff);
    xl(16'h0000, 16'h8000, 32'h0080_0100);
    xl(16'h0700, 16'h7f03, 32'h007f_0103);
    $display("xlate done");
    apb(1'b1, 8'h28, 32'h1234);
    chk({31'h0, er}, 32'h1, "werr");
    rdc(8'h40, 32'h0, "rerr");
    chk({31'h0, er}, 32'h1, "rerr flag");
    $display("bus done");
    apb(1'b1, `CDR_OFF_PS, 32'h0060);
    for (int l = 0; l < 4; l++) begin
      @(posedge clk);
      lvl <= 2'(l);
      req <= 1'b1;
      repeat (2) @(posedge clk);
      chk({31'h0, take}, 32'(l < 2), "take");
    end
    lvl <= 2'h0;
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, `CDR_OFF_PS, {16'h0, ipv[j]});
      repeat (2) @(posedge clk);
      rdc(`CDR_OFF_STAT, stv[j], "stat");
    end
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(`CDR_OFF_PS, 32'h0, "ps rst");
    chk({31'h0, en}, 32'h0, "en rst");
    $display("irq done");
    conclude;
  end
  initial begin
    #40000;
    error_cnt++;
    $display("ERROR %0t timeout", $time);
    conclude;
  end
endmodule
